//--- pkg/ppgs_pkg.sv
// constants and types for the push-pull gate sequencer
package ppgs_pkg;
   // system clock
   localparam int unsigned SYS_CLK_HZ      = 50_000_000;
   // switching frequency limits and nominal in kHz
   localparam int unsigned FSW_MIN_KHZ     = 300;
   localparam int unsigned FSW_MAX_KHZ     = 550;
   localparam int unsigned FSW_NOM_KHZ     = 375;
   // half period counts derived from the clock rate (min time rounds up)
   localparam int unsigned HALF_MIN_CYC    = (SYS_CLK_HZ + 2*FSW_MAX_KHZ*1000 - 1)
                                             / (2*FSW_MAX_KHZ*1000);
   localparam int unsigned HALF_MAX_CYC    = SYS_CLK_HZ / (2*FSW_MIN_KHZ*1000);
   localparam int unsigned HALF_NOM_CYC    = SYS_CLK_HZ / (2*FSW_NOM_KHZ*1000);
   // dither: +-10.6 percent in steps of about 1.5 percent, as cycles
   localparam int unsigned DITH_STEP_CYC   = 1;
   localparam int unsigned DITH_STEPS      = 7;
   // dead time in ns and cycles
   localparam int unsigned DEAD_NS         = 165;
   localparam int unsigned DEAD_CYC        = (DEAD_NS * 50 + 999) / 1000;
   // hiccup delay after over-temperature clears
   localparam int unsigned HICCUP_MS       = 64;
   localparam int unsigned HICCUP_CYC      = HICCUP_MS * (SYS_CLK_HZ / 1000);
   // counter widths
   localparam int unsigned CNT_W           = 8;
   localparam int unsigned HIC_W           = 23;
   // sequencer states, gray along off -> run -> hiccup
   typedef enum logic [1:0] {
      PPGS_OFF    = 2'b00,
      PPGS_RUN    = 2'b01,
      PPGS_HICCUP = 2'b11
   } ppgs_state_t;
endpackage : ppgs_pkg

//--- core/ppgs_push_pull_gate_sequencer.sv
// push-pull gate sequencer: divider, dither, dead time, supply and thermal sequencing

module ppgs_push_pull_gate_sequencer #(
   parameter int unsigned DEAD_CYCLES  = ppgs_pkg::DEAD_CYC,
   parameter int unsigned HICCUP_CYCLES = ppgs_pkg::HICCUP_CYC
) (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   // supply and thermal indications
   input  wire logic supplyGood,
   input  wire logic overTemp,
   // gate drives
   output logic      gateDriveA,
   output logic      gateDriveB,
   // status
   output logic      switching
);
   ppgs_pkg::ppgs_state_t stateQ, stateD;
   logic [ppgs_pkg::CNT_W-1:0] halfCntQ;
   logic [ppgs_pkg::CNT_W-1:0] deadCntQ;
   logic [ppgs_pkg::CNT_W-1:0] halfLen;
   logic [3:0]                 dithQ;
   logic                       dithUpQ;
   logic                       phaseQ;
   logic                       gateAQ, gateBQ;
   logic [ppgs_pkg::HIC_W-1:0] hicCntQ;

   localparam logic [ppgs_pkg::CNT_W-1:0] DEAD_LEN = ppgs_pkg::CNT_W'(DEAD_CYCLES);
   localparam logic [ppgs_pkg::CNT_W-1:0] HALF_BASE =
      ppgs_pkg::CNT_W'(ppgs_pkg::HALF_NOM_CYC - ppgs_pkg::DITH_STEPS);
   localparam logic [3:0] DITH_TOP = 4'(2 * ppgs_pkg::DITH_STEPS);
   localparam logic [ppgs_pkg::HIC_W-1:0] HIC_ONE = {{(ppgs_pkg::HIC_W-1){1'b0}}, 1'b1};
   localparam logic [ppgs_pkg::CNT_W-1:0] DEAD_GAP = DEAD_LEN + 8'h01;

   wire running  = (stateQ == ppgs_pkg::PPGS_RUN);
   wire halfDone = (halfCntQ == halfLen - 8'h01);
   wire deadDone = (deadCntQ == 8'h00);
   wire hicDone  = (hicCntQ == ppgs_pkg::HIC_W'(HICCUP_CYCLES - 1));

   // triangle dither on the half period, centred on nominal
   assign halfLen = HALF_BASE + {4'h0, dithQ};

   // sequencing: supply loss and heat both stop, heat then waits out the hiccup
   always_comb begin
      stateD = stateQ;
      case (stateQ)
         ppgs_pkg::PPGS_OFF:    if (supplyGood && !overTemp) stateD = ppgs_pkg::PPGS_RUN;
         ppgs_pkg::PPGS_RUN:    if (!supplyGood) stateD = ppgs_pkg::PPGS_OFF;
                                else if (overTemp) stateD = ppgs_pkg::PPGS_HICCUP;
         ppgs_pkg::PPGS_HICCUP: if (!supplyGood) stateD = ppgs_pkg::PPGS_OFF;
                                else if (!overTemp && hicDone) stateD = ppgs_pkg::PPGS_RUN;
         default:               stateD = ppgs_pkg::PPGS_OFF;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) stateQ <= ppgs_pkg::PPGS_OFF;
      else     stateQ <= stateD;
   end

   // hiccup timer counts only while the die is cool; a new overheat restarts it
   always_ff @(posedge sys_clk) begin
      if (rst || stateQ != ppgs_pkg::PPGS_HICCUP || overTemp) hicCntQ <= '0;
      else if (!hicDone) hicCntQ <= hicCntQ + HIC_ONE;
   end
   // nothing may switch while the hiccup wait runs
   a_hiccup_hold: assert property (@(posedge sys_clk) disable iff (rst)
      (stateQ == ppgs_pkg::PPGS_HICCUP) |-> !gateDriveA && !gateDriveB && !switching)
      else $error("gate high during hiccup");
   // a fresh overheat throws away the cool time already counted
   a_hiccup_restart: assert property (@(posedge sys_clk) disable iff (rst)
      (stateQ == ppgs_pkg::PPGS_HICCUP && overTemp) |=> hicCntQ == '0)
      else $error("hiccup timer not restarted");

   // phase divider: each half period flips the phase, 50% duty per phase
   always_ff @(posedge sys_clk) begin
      if (rst || !running) begin
         halfCntQ <= '0;
         phaseQ   <= 1'b0;
      end else if (halfDone) begin
         halfCntQ <= '0;
         phaseQ   <= ~phaseQ;
      end else begin
         halfCntQ <= halfCntQ + 8'h01;
      end
   end
   // leaving run must clear the divider before the next start
   a_off_entry: assert property (@(posedge sys_clk) disable iff (rst)
      (running && stateD != ppgs_pkg::PPGS_RUN) |=> (!gateDriveA && !gateDriveB) ##1
      (!phaseQ && halfCntQ == 8'h00))
      else $error("stop did not restart the phase");

   // dither steps once per full period so both halves stay equal
   always_ff @(posedge sys_clk) begin
      if (rst || !running) begin
         dithQ   <= 4'h0;
         dithUpQ <= 1'b1;
      end else if (halfDone && phaseQ) begin
         if (dithUpQ) begin
            if (dithQ == DITH_TOP - 4'h1) dithUpQ <= 1'b0;
            dithQ <= dithQ + 4'h1;
         end else begin
            if (dithQ == 4'h1) dithUpQ <= 1'b1;
            dithQ <= dithQ - 4'h1;
         end
      end
   end
   // the dither must stay inside its triangle and move every full period
   a_dither_range: assert property (@(posedge sys_clk) disable iff (rst)
      dithQ <= DITH_TOP) else $error("dither beyond its top");
   a_dither_step: assert property (@(posedge sys_clk) disable iff (rst)
      (running && halfDone && phaseQ) |=> dithQ != $past(dithQ))
      else $error("dither did not move");

   // dead-time counter reloads on every phase change
   always_ff @(posedge sys_clk) begin
      if (rst || !running) deadCntQ <= DEAD_LEN;
      else if (halfDone)   deadCntQ <= DEAD_LEN;
      else if (!deadDone)  deadCntQ <= deadCntQ - 8'h01;
   end

   // gates use the next state so a stop drops them in the same edge
   wire runNext = (stateD == ppgs_pkg::PPGS_RUN) && running;
   wire enA     = runNext && deadDone && !halfDone && !phaseQ;
   wire enB     = runNext && deadDone && !halfDone &&  phaseQ;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gateAQ <= 1'b0;
         gateBQ <= 1'b0;
      end else begin
         gateAQ <= enA;
         gateBQ <= enB;
      end
   end

   assign gateDriveA = gateAQ;
   assign gateDriveB = gateBQ;
   assign switching  = running;

   // pulse bookkeeping for the checks below; no effect on the outputs
   logic [ppgs_pkg::CNT_W-1:0] gapCntQ;
   logic [ppgs_pkg::CNT_W-1:0] hiCntQ;
   logic [ppgs_pkg::CNT_W-1:0] hiAQ;
   wire anyGate = gateDriveA || gateDriveB;

   // cycles both gates have been low, saturating so a long off time cannot wrap
   always_ff @(posedge sys_clk) begin
      if (rst || anyGate)         gapCntQ <= '0;
      else if (gapCntQ != 8'hFF) gapCntQ <= gapCntQ + 8'h01;
   end

   // length of the current pulse, and of the last A pulse for the B pulse to match
   always_ff @(posedge sys_clk) begin
      if (rst || !anyGate) hiCntQ <= '0;
      else                 hiCntQ <= hiCntQ + 8'h01;
   end
   always_ff @(posedge sys_clk) begin
      if (rst)             hiAQ <= '0;
      else if (gateDriveA) hiAQ <= hiCntQ + 8'h01;
   end

   // the gap holds the reload plus the edge that drops the old gate
   a_dead_b: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(gateDriveB) |-> gapCntQ == DEAD_GAP) else $error("dead gap before B wrong");
   // a start after a stop has waited at least as long
   a_dead_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(gateDriveA) |-> gapCntQ >= DEAD_GAP) else $error("dead gap before A short");
   // both halves of one period share a dither step, so their pulses match
   a_half_match: assert property (@(posedge sys_clk) disable iff (rst)
      ($fell(gateDriveB) && switching) |-> hiCntQ == hiAQ)
      else $error("A and B pulses differ");
   // each gate only follows its own phase
   a_gate_phase_a: assert property (@(posedge sys_clk) disable iff (rst)
      gateDriveA |-> !$past(phaseQ)) else $error("A high in phase B");
   a_gate_phase_b: assert property (@(posedge sys_clk) disable iff (rst)
      gateDriveB |-> $past(phaseQ)) else $error("B high in phase A");

   // checks
   a_gates_exclusive: assert property (@(posedge sys_clk) disable iff (rst)
      !(gateDriveA && gateDriveB)) else $error("both gates high");
   a_dead_gap: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(gateDriveA) |-> !gateDriveB [*2]) else $error("no dead time after A");
   a_off_low: assert property (@(posedge sys_clk) disable iff (rst)
      (stateQ == ppgs_pkg::PPGS_OFF) |-> !gateDriveA && !gateDriveB)
      else $error("gate high in off-mode");
   a_heat_stop: assert property (@(posedge sys_clk) disable iff (rst)
      (running && overTemp) |=> !gateDriveA && !gateDriveB) else $error("no stop on heat");
   a_uv_stop: assert property (@(posedge sys_clk) disable iff (rst)
      !supplyGood |=> !gateDriveA && !gateDriveB && !switching) else $error("no stop on uv");
   a_start_up: assert property (@(posedge sys_clk) disable iff (rst)
      (stateQ == ppgs_pkg::PPGS_OFF && supplyGood && !overTemp) |=> switching)
      else $error("no start on supply good");
   a_phase_restart: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(switching) |-> !phaseQ && halfCntQ == 8'h00) else $error("phase not reset");
   a_half_range: assert property (@(posedge sys_clk) disable iff (rst)
      halfLen >= 8'(ppgs_pkg::HALF_MIN_CYC) && halfLen <= 8'(ppgs_pkg::HALF_MAX_CYC))
      else $error("half period out of range");
   a_resume_wait: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(switching) && $past(stateQ) == ppgs_pkg::PPGS_HICCUP |-> $past(hicDone))
      else $error("resumed before hiccup");
   a_phase_toggle: assert property (@(posedge sys_clk) disable iff (rst)
      (running && halfDone && stateD == ppgs_pkg::PPGS_RUN) |=> phaseQ != $past(phaseQ))
      else $error("phase did not toggle");

   c_gate_a: cover property (@(posedge sys_clk) $rose(gateDriveA));
   c_gate_b: cover property (@(posedge sys_clk) $rose(gateDriveB));
   c_hiccup: cover property (@(posedge sys_clk) stateQ == ppgs_pkg::PPGS_HICCUP && hicDone);
   c_uv_off: cover property (@(posedge sys_clk) running && !supplyGood);
   c_heat_trip: cover property (@(posedge sys_clk) running && overTemp);
endmodule : ppgs_push_pull_gate_sequencer

//--- tb/ppgs_xfmr_model.sv
// primary winding and low-side switch pair seen by the sequencer
module ppgs_xfmr_model (
   // gate drives
   input  wire logic gateA,
   input  wire logic gateB,
   // drain nodes and fault flag
   output logic      drainOutA,
   output logic      drainOutB,
   output logic      shorted
);
   timeunit 1ns;
   timeprecision 1ps;
   // an off switch floats, so the primary pulls its drain up
   assign drainOutA = ~gateA;
   assign drainOutB = ~gateB;
   // both switches on would short the primary ends
   assign shorted   = gateA & gateB;
endmodule : ppgs_xfmr_model

//--- tb/ppgs_push_pull_gate_sequencer_tb.sv
// self-checking bench for the push-pull gate sequencer
module ppgs_push_pull_gate_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEAD = 9;
   localparam int HIC  = 20;
   typedef struct packed {logic gate; logic [31:0] gap;} ppgs_note_t;
   logic        sys_clk = 1'b0, rst = 1'b1, supplyGood = 1'b0, overTemp = 1'b0;
   logic        gateDriveA, gateDriveB, switching, drainOutA, drainOutB, shorted;
   logic        prevA = 1'b0, prevB = 1'b0, perOk = 1'b0;
   logic [31:0] rng = 32'h2, gap = 32'h0, per = 32'h0, wA = 32'h0, wB = 32'h0;
   logic [31:0] pMin = 32'hFFFF_FFFF, pMax = 32'h0;
   int          failures = 0, checked = 0;
   ppgs_note_t  note, notes[$];
   always #10 sys_clk = ~sys_clk;
   ppgs_push_pull_gate_sequencer #(.DEAD_CYCLES(DEAD), .HICCUP_CYCLES(HIC)) u_dut (
      .sys_clk(sys_clk), .rst(rst), .supplyGood(supplyGood), .overTemp(overTemp),
      .gateDriveA(gateDriveA), .gateDriveB(gateDriveB), .switching(switching));
   ppgs_xfmr_model u_xfmr (.gateA(gateDriveA), .gateB(gateDriveB),
      .drainOutA(drainOutA), .drainOutB(drainOutB), .shorted(shorted));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xorshift
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (exp !== got) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic final_report();
      if (failures == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : final_report
   // notes for n gate pulses, first on A, then wait till all are seen
   task automatic run_halves(input int n);
      notes.push_back('{1'b0, DEAD + 1});
      // later gaps also count the edge that drops the old gate
      for (int i = 1; i < n; i++) notes.push_back('{i[0], DEAD + 1});
      for (int t = 0; t < 9000 && notes.size() > 0; t++) @(negedge sys_clk);
      chk("notes left", 0, notes.size());
      rng = xorshift(rng);
      repeat (rng[4:0] + 1) @(negedge sys_clk); // stop early in a half, before the next rise
   endtask : run_halves
   // monitor: every rise must match the oldest note
   always @(negedge sys_clk) if (!rst) begin
      chk("gates apart", 0, shorted);
      if (!switching) chk("drains float", 32'h3, {drainOutA, drainOutB});
      if ((gateDriveA && !prevA) || (gateDriveB && !prevB)) begin
         if (notes.size() == 0) chk("stray rise", 0, 1);
         else begin
            note = notes.pop_front();
            chk("gate", note.gate, gateDriveB);
            chk("dead gap", note.gap, gap);
         end
         gap = 0;
      end
      if (gateDriveA && !prevA) begin
         if (perOk) chk("period band", 1, per * 550_000 >= 50_000_000 && per * 300_000 <= 50_000_000);
         if (perOk && per < pMin) pMin = per;
         if (perOk && per > pMax) pMax = per;
         per = 0;
         perOk = 1'b1;
      end
      if (prevB && !gateDriveB && switching) chk("half balance", wA, wB);
      if (prevB && !gateDriveB) {wA, wB} = 64'h0;
      if (!switching) {gap, per, wA, wB, perOk} = 129'h0;
      else begin
         per++;
         if (!gateDriveA && !gateDriveB) gap++;
      end
      wA += gateDriveA;
      wB += gateDriveB;
      {prevA, prevB} = {gateDriveA, gateDriveB};
   end
   initial begin
      repeat (5) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      supplyGood = 1'b1;
      run_halves(40);
      // thermal trip mid-half, then hiccup wait
      overTemp = 1'b1;
      @(negedge sys_clk);
      chk("thermal stop", 0, {gateDriveA, gateDriveB, switching});
      repeat (rng[6:0] + 2) @(negedge sys_clk);
      overTemp = 1'b0;
      repeat (HIC - 1) @(negedge sys_clk);
      chk("hiccup hold", 0, switching);
      for (int t = 0; t < 3 && !switching; t++) @(negedge sys_clk);
      chk("hiccup resume", 1, switching);
      run_halves(6);
      // supply loss mid-half
      supplyGood = 1'b0;
      @(negedge sys_clk);
      chk("supply stop", 0, {gateDriveA, gateDriveB, switching});
      repeat (rng[7:0] + 2) @(negedge sys_clk);
      supplyGood = 1'b1;
      run_halves(6);
      // heat then supply loss: supply loss wins, restart needs no hiccup wait
      overTemp = 1'b1;
      @(negedge sys_clk);
      supplyGood = 1'b0;
      @(negedge sys_clk);
      overTemp = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("uv in hiccup", 0, switching);
      supplyGood = 1'b1;
      @(negedge sys_clk);
      chk("restart from off", 1, switching);
      run_halves(6);
      chk("dither spread", 1, pMax > pMin);
      final_report();
   end
   // watchdog
   initial begin
      repeat (60000) @(posedge sys_clk);
      failures++;
      final_report();
   end
endmodule : ppgs_push_pull_gate_sequencer_tb
